// ### shared/uef_pkg.sv
package uef_pkg;
  // Register addresses on the host port
  localparam logic [3:0] A_THR   = 4'h0;
  localparam logic [3:0] A_IER   = 4'h1;
  localparam logic [3:0] A_ISR   = 4'h2;
  localparam logic [3:0] A_MCR   = 4'h3;
  localparam logic [3:0] A_MS    = 4'h4;
  localparam logic [3:0] A_LAC   = 4'h5;
  localparam logic [3:0] A_SPR   = 4'h6;
  localparam logic [3:0] A_FEATURE_CONTROL  = 4'h7;
  localparam logic [3:0] A_EFR   = 4'h8;
  localparam logic [3:0] A_SECOND_STOP_CHARACTER = 4'h9;

  // Reset values and write masks
  localparam logic [7:0] SPR_RST    = 8'hFF;
  localparam logic [7:0] IER_GATE_M = 8'hE0;
  localparam logic [7:0] MCR_GATE_M = 8'hEC;
  localparam logic [7:0] LAC_GATE_M = 8'hFC;
  localparam logic [7:0] LAC_WR_M   = 8'hFD;
  localparam logic [7:0] FEATURE_CONTROL_M     = 8'h30;

  // Field positions
  localparam int IER_MS    = 3;
  localparam int MCR_DTR   = 0;
  localparam int MCR_RTS   = 1;
  localparam int MCR_SEL   = 2;
  localparam int LAC_9BIT  = 0;
  localparam int LAC_RXDIS = 2;
  localparam int LAC_TXDIS = 3;
  localparam int LAC_DLY_H = 7;
  localparam int LAC_DLY_L = 4;
  localparam int FEATURE_CONTROL_IRP  = 4;
  localparam int FEATURE_CONTROL_485  = 5;
  localparam int EFR_GATE  = 4;
  localparam int EFR_SPEC  = 5;
  localparam int EFR_ARTS  = 6;
  localparam int EFR_ACTS  = 7;
  localparam int ISR_SPEC  = 4;
  localparam int ISR_XOFF  = 5;

  // Receive compare set that swallows the second stop character
  localparam logic [1:0] RXF_X2 = 2'h1;

  // Transmit frame lengths and receive data bit counts, in bit times
  localparam logic [3:0] TX_BITS_8 = 4'hA;
  localparam logic [3:0] TX_BITS_9 = 4'hB;
  localparam logic [3:0] RX_DATA_8 = 4'h8;
  localparam logic [3:0] RX_DATA_9 = 4'h9;

  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT, TX_TURN} uef_tx_st_t;
  typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_STOP} uef_rx_st_t;
endpackage

// ### src/uef_fifo.sv
`timescale 1ns/10ps
module uef_fifo
  import uef_pkg::*;
#(
  parameter int W     = 9,
  parameter int DEPTH = 4
) (
  input  wire logic         sys_clk_in,
  input  wire logic         reset_in,
  input  wire logic         ce_in,
  input  wire logic         in_valid_in,
  input  wire logic [W-1:0] in_data_in,
  output logic              in_ready_out,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic      [W-1:0] out_data_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    nempty;
    logic                    nfull;
  } uef_fifo_st_t;

  uef_fifo_st_t st;
  uef_fifo_st_t next_st;
  logic         push;
  logic         pop;

  always_comb begin
    next_st = st;
    push    = in_valid_in && st.nfull;
    pop     = out_ready_in && st.nempty;
    if (push) begin
      next_st.mem[st.wp] = in_data_in;
      next_st.wp = (st.wp == AW'(DEPTH - 1)) ? '0 : st.wp + 1'b1;
    end
    if (pop) begin
      next_st.rp = (st.rp == AW'(DEPTH - 1)) ? '0 : st.rp + 1'b1;
    end
    if (push && !pop) begin
      next_st.cnt = st.cnt + 1'b1;
    end else if (pop && !push) begin
      next_st.cnt = st.cnt - 1'b1;
    end
    next_st.nempty = (next_st.cnt != '0);
    next_st.nfull  = (next_st.cnt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      st       <= '0;
      st.nfull <= 1'b1;
    end else if (ce_in) begin
      st <= next_st;
    end
  end

  assign in_ready_out  = st.nfull;
  assign out_valid_out = st.nempty;
  assign out_data_out  = st.mem[st.rp];

  a_fifo_full_stall: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    st.cnt == (AW+1)'(DEPTH) |-> !in_ready_out && out_valid_out)
    else $error("fifo full but still accepting");
endmodule

// ### src/uef_sync.sv
`timescale 1ns/10ps
module uef_sync
  import uef_pkg::*;
#(
  parameter int         W   = 3,
  parameter logic [2:0] RST = 3'h7
) (
  input  wire logic         sys_clk_in,
  input  wire logic         reset_in,
  input  wire logic         ce_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } uef_sync_st_t;

  uef_sync_st_t st;
  uef_sync_st_t next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = d_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // Only a level seen twice in a row is passed on
    for (int i = 0; i < W; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.q[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      st <= {4{W'(RST)}};
    end else if (ce_in) begin
      st <= next_st;
    end
  end

  assign q_out = st.q;
endmodule

// ### src/uef_top.sv
`timescale 1ns/10ps
module uef_top
  import uef_pkg::*;
#(
  parameter int LW    = 5,
  parameter int DEPTH = 4
) (
  input  wire logic          sys_clk_in,
  input  wire logic          reset_in,
  input  wire logic          ce_in,
  input  wire logic [3:0]    reg_addr_in,
  input  wire logic          reg_wr_in,
  input  wire logic          reg_rd_in,
  input  wire logic [7:0]    reg_wdata_in,
  output logic      [7:0]    reg_rdata_out,
  input  wire logic          tx_ninth_in,
  output logic               tx_ready_out,
  input  wire logic          bit_tick_in,
  input  wire logic          rx_in,
  input  wire logic          cts_n_in,
  input  wire logic          dsr_n_in,
  input  wire logic [LW-1:0] rx_level_in,
  input  wire logic [LW-1:0] rx_trig_in,
  input  wire logic [LW-1:0] rx_upper_in,
  input  wire logic [LW-1:0] rx_lower_in,
  output logic               tx_out,
  output logic               rts_n_out,
  output logic               dtr_n_out,
  output logic      [8:0]    rx_data_out,
  output logic               rx_valid_out,
  output logic               modem_irq_out,
  output logic               tx_irq_out,
  output logic               special_irq_out,
  output logic               xoff_irq_out,
  output logic               rx_trig_irq_out,
  output logic      [1:0]    tx_flow_sel_out,
  output logic      [1:0]    rx_flow_sel_out
);
  typedef struct packed {
    logic [7:0]  interrupt_enable;
    logic [7:0]  modem_control;
    logic [7:0]  lac;
    logic [7:0]  scratch_pad;
    logic [7:0]  feature_control;
    logic [7:0]  enhanced_feature;
    logic [7:0]  second_stop_character;
    logic        cts_q;
    logic        dsr_q;
    logic        d_cts;
    logic        d_dsr;
    logic        spec;
    logic        xoff;
    uef_tx_st_t  tx_st;
    logic [10:0] tx_sh;
    logic [3:0]  tx_cnt;
    logic [3:0]  ta_cnt;
    uef_rx_st_t  rx_st;
    logic [8:0]  rx_sh;
    logic [3:0]  rx_cnt;
    logic        rx_blk;
    logic        hold;
    logic        tx_pin;
    logic        rts_n;
    logic        dtr_n;
    logic [7:0]  rdata;
    logic [8:0]  rx_data;
    logic        rx_valid;
    logic        modem_irq;
    logic        tx_irq;
    logic        trig_irq;
  } uef_top_st_t;

  uef_top_st_t st;
  uef_top_st_t next_st;

  logic [2:0] pins_s;
  logic       rx_s;
  logic       cts_s;
  logic       dsr_s;
  logic       fifo_valid;
  logic [8:0] fifo_data;
  logic       thr_wr;
  logic       load_now;
  logic       done_now;
  logic       can_load;
  logic       sel_hi;
  logic       rxd;
  logic       rx_done;
  logic       match;
  logic       drop;
  logic       rd_ms;
  logic       rd_isr;
  logic       gate;
  logic [8:0] chr;

  // Pins cross in from the line side
  uef_sync #(.W(3), .RST(3'h7)) u_sync (
    .sys_clk_in (sys_clk_in),
    .reset_in   (reset_in),
    .ce_in      (ce_in),
    .d_in       ({dsr_n_in, cts_n_in, rx_in}),
    .q_out      (pins_s)
  );
  assign rx_s  = pins_s[0];
  assign cts_s = pins_s[1];
  assign dsr_s = pins_s[2];

  // Writes are refused while full; tx_ready_out tells the host
  uef_fifo #(.W(9), .DEPTH(DEPTH)) u_txq (
    .sys_clk_in    (sys_clk_in),
    .reset_in      (reset_in),
    .ce_in         (ce_in),
    .in_valid_in   (thr_wr),
    .in_data_in    ({tx_ninth_in, reg_wdata_in}),
    .in_ready_out  (tx_ready_out),
    .out_valid_out (fifo_valid),
    .out_ready_in  (load_now),
    .out_data_out  (fifo_data)
  );

  function automatic logic [7:0] gate_wr(input logic [7:0] old, input logic [7:0] nw,
                                         input logic [7:0] m, input logic g);
    gate_wr = g ? nw : ((old & m) | (nw & ~m));
  endfunction

  always_comb begin
    next_st  = st;
    thr_wr   = reg_wr_in && (reg_addr_in == A_THR);
    gate     = st.enhanced_feature[EFR_GATE];
    load_now = 1'b0;
    done_now = 1'b0;
    rx_done  = 1'b0;
    rd_ms    = reg_rd_in && (reg_addr_in == A_MS);
    rd_isr   = reg_rd_in && (reg_addr_in == A_ISR);
    sel_hi   = st.modem_control[MCR_SEL] ? dsr_s : cts_s;
    can_load = fifo_valid && !st.lac[LAC_TXDIS]
               && !(st.enhanced_feature[EFR_ACTS] && sel_hi);
    rxd      = rx_s ^ st.feature_control[FEATURE_CONTROL_IRP];

    if (reg_wr_in) begin
      case (reg_addr_in)
        A_IER:   next_st.interrupt_enable = gate_wr(st.interrupt_enable, reg_wdata_in, IER_GATE_M, gate);
        A_MCR:   next_st.modem_control = gate_wr(st.modem_control, reg_wdata_in, MCR_GATE_M, gate);
        A_LAC:   next_st.lac = gate_wr(st.lac, reg_wdata_in & LAC_WR_M,
                                       LAC_GATE_M, gate);
        A_SPR:   next_st.scratch_pad = reg_wdata_in;
        A_FEATURE_CONTROL:  next_st.feature_control = reg_wdata_in & FEATURE_CONTROL_M;
        A_EFR:   next_st.enhanced_feature = reg_wdata_in;
        A_SECOND_STOP_CHARACTER: next_st.second_stop_character = reg_wdata_in;
        default: ;
      endcase
    end

    // Change seen in the clearing read is kept
    next_st.cts_q = cts_s;
    next_st.dsr_q = dsr_s;
    next_st.d_cts = (st.cts_q != cts_s) || (st.d_cts && !rd_ms);
    next_st.d_dsr = (st.dsr_q != dsr_s) || (st.d_dsr && !rd_ms);

    if (reg_rd_in) begin
      case (reg_addr_in)
        A_IER:   next_st.rdata = st.interrupt_enable;
        A_ISR:   next_st.rdata = 8'(({7'h00, st.spec} << ISR_SPEC) |
                                    ({7'h00, st.xoff} << ISR_XOFF));
        A_MCR:   next_st.rdata = st.modem_control;
        A_MS:    next_st.rdata = {2'h0, ~st.dsr_q, ~st.cts_q, 2'h0, st.d_dsr, st.d_cts};
        A_SPR:   next_st.rdata = st.scratch_pad;
        A_FEATURE_CONTROL:  next_st.rdata = st.feature_control;
        A_EFR:   next_st.rdata = st.enhanced_feature;
        default: next_st.rdata = 8'h00;
      endcase
    end

    case (st.tx_st)
      TX_IDLE: begin
        load_now = can_load;
      end
      TX_SHIFT: begin
        if (bit_tick_in && !st.lac[LAC_TXDIS]) begin
          if (st.tx_cnt == 4'h0) begin
            done_now = 1'b1;
            load_now = can_load;
            if (!can_load && st.feature_control[FEATURE_CONTROL_485]) begin
              next_st.tx_st  = TX_TURN;
              next_st.ta_cnt = st.lac[LAC_DLY_H:LAC_DLY_L];
            end else if (!can_load) begin
              next_st.tx_st = TX_IDLE;
            end
          end else begin
            next_st.tx_pin = st.tx_sh[0];
            next_st.tx_sh  = {1'b1, st.tx_sh[10:1]};
            next_st.tx_cnt = st.tx_cnt - 4'h1;
          end
        end
      end
      TX_TURN: begin
        load_now = can_load;
        if (!can_load && (st.ta_cnt == 4'h0 || !st.feature_control[FEATURE_CONTROL_485])) begin
          next_st.tx_st = TX_IDLE;
        end else if (!can_load && bit_tick_in) begin
          next_st.ta_cnt = st.ta_cnt - 4'h1;
        end
      end
      default: next_st.tx_st = TX_IDLE;
    endcase

    if (load_now) begin
      // Start bit waits for the next tick so the direction pin leads it
      next_st.tx_st  = TX_SHIFT;
      next_st.tx_sh  = {1'b1, st.lac[LAC_9BIT] ? fifo_data[8] : 1'b1, fifo_data[7:0], 1'b0};
      next_st.tx_cnt = st.lac[LAC_9BIT] ? TX_BITS_9 : TX_BITS_8;
    end

    // Receiver samples once per bit tick
    chr = st.lac[LAC_9BIT] ? st.rx_sh : {1'b0, st.rx_sh[8:1]};
    case (st.rx_st)
      RX_IDLE: begin
        if (bit_tick_in && !rxd && !st.rx_blk) begin
          next_st.rx_st  = RX_DATA;
          next_st.rx_cnt = st.lac[LAC_9BIT] ? RX_DATA_9 : RX_DATA_8;
        end
      end
      RX_DATA: begin
        if (bit_tick_in) begin
          next_st.rx_sh  = {rxd, st.rx_sh[8:1]};
          next_st.rx_cnt = st.rx_cnt - 4'h1;
          if (st.rx_cnt == 4'h1) begin
            next_st.rx_st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (bit_tick_in) begin
          rx_done       = 1'b1;
          next_st.rx_st = RX_IDLE;
        end
      end
      default: next_st.rx_st = RX_IDLE;
    endcase
    // One more character is let through after the disable is set
    next_st.rx_blk = st.lac[LAC_RXDIS] && (st.rx_blk || rx_done);

    match = rx_done && st.enhanced_feature[EFR_SPEC] && (chr[7:0] == st.second_stop_character);
    drop  = match && (st.enhanced_feature[1:0] == RXF_X2);
    next_st.rx_valid = rx_done && !drop;
    if (rx_done) begin
      next_st.rx_data = chr;
    end
    next_st.spec = match || (st.spec && !rd_isr);
    next_st.xoff = drop || (st.xoff && !rd_isr);

    if (rx_level_in >= rx_upper_in) begin
      next_st.hold = 1'b1;
    end else if (rx_level_in < rx_lower_in) begin
      next_st.hold = 1'b0;
    end
    next_st.trig_irq = st.enhanced_feature[EFR_ARTS] && (rx_level_in >= rx_trig_in);

    if (next_st.feature_control[FEATURE_CONTROL_485]) begin
      next_st.rts_n = (next_st.tx_st != TX_IDLE);
    end else if (next_st.enhanced_feature[EFR_ARTS] && !next_st.modem_control[MCR_SEL] && next_st.modem_control[MCR_RTS]) begin
      next_st.rts_n = next_st.hold;
    end else begin
      next_st.rts_n = ~next_st.modem_control[MCR_RTS];
    end
    if (next_st.enhanced_feature[EFR_ARTS] && next_st.modem_control[MCR_SEL] && next_st.modem_control[MCR_DTR]) begin
      next_st.dtr_n = next_st.hold;
    end else begin
      next_st.dtr_n = ~next_st.modem_control[MCR_DTR];
    end

    next_st.tx_irq = next_st.feature_control[FEATURE_CONTROL_485] ? (!fifo_valid && next_st.tx_st == TX_IDLE)
                                            : !fifo_valid;
    next_st.modem_irq = (next_st.d_cts || next_st.d_dsr) && next_st.interrupt_enable[IER_MS];
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      st        <= '0;
      st.scratch_pad    <= SPR_RST;
      st.cts_q  <= 1'b1;
      st.dsr_q  <= 1'b1;
      st.tx_sh  <= '1;
      st.tx_pin <= 1'b1;
      st.rts_n  <= 1'b1;
      st.dtr_n  <= 1'b1;
      st.tx_irq <= 1'b1;
    end else if (ce_in) begin
      st <= next_st;
    end
  end

  assign reg_rdata_out   = st.rdata;
  assign tx_out          = st.tx_pin;
  assign rts_n_out       = st.rts_n;
  assign dtr_n_out       = st.dtr_n;
  assign rx_data_out     = st.rx_data;
  assign rx_valid_out    = st.rx_valid;
  assign modem_irq_out   = st.modem_irq;
  assign tx_irq_out      = st.tx_irq;
  assign special_irq_out = st.spec;
  assign xoff_irq_out    = st.xoff;
  assign rx_trig_irq_out = st.trig_irq;
  assign tx_flow_sel_out = st.enhanced_feature[3:2];
  assign rx_flow_sel_out = st.enhanced_feature[1:0];

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  sequence s_rs485_load;
    ce_in && load_now && st.feature_control[FEATURE_CONTROL_485] && !reg_wr_in;
  endsequence
  sequence s_dir_high;
    rts_n_out && st.tx_st == TX_SHIFT;
  endsequence

  a_delta_cts_set: assert property (ce_in && st.cts_q != cts_s |=> st.d_cts)
    else $error("delta cts missed");
  a_tx_halt_hold: assert property (ce_in && st.lac[LAC_TXDIS] && st.tx_st == TX_IDLE
    && !(reg_wr_in && reg_addr_in == A_LAC) |=> st.tx_st == TX_IDLE)
    else $error("transmitter started while disabled");
  a_rs485_dir_up: assert property (s_rs485_load |=> s_dir_high)
    else $error("direction not high before start bit");
  a_turn_load: assert property (ce_in && done_now && !can_load && st.feature_control[FEATURE_CONTROL_485]
    |=> st.tx_st == TX_TURN && st.ta_cnt == $past(st.lac[LAC_DLY_H:LAC_DLY_L]))
    else $error("turnaround delay not loaded");
  a_turn_count: assert property (ce_in && st.tx_st == TX_TURN && st.ta_cnt != 4'h0
    && bit_tick_in && !can_load && st.feature_control[FEATURE_CONTROL_485]
    |=> st.ta_cnt == $past(st.ta_cnt) - 4'h1 && rts_n_out)
    else $error("turnaround count wrong");
  a_gate_freeze: assert property (ce_in && !st.enhanced_feature[EFR_GATE] && reg_wr_in
    && reg_addr_in == A_LAC |=> st.lac[7:2] == $past(st.lac[7:2]))
    else $error("gated field changed while latched");
  a_rx_blocked: assert property (st.rx_blk && st.lac[LAC_RXDIS] |-> st.rx_st == RX_IDLE)
    else $error("receiver ran while blocked");
  a_spec_drop: assert property (ce_in && drop |=> !rx_valid_out && special_irq_out
    && xoff_irq_out)
    else $error("second stop character stored");
  a_cts_stop: assert property (ce_in && st.enhanced_feature[EFR_ACTS] && sel_hi && st.tx_st == TX_IDLE
    && !reg_wr_in |=> st.tx_st == TX_IDLE)
    else $error("sent while flow input high");
  a_tx_irq_src: assert property (st.feature_control[FEATURE_CONTROL_485] && st.tx_st == TX_SHIFT
    |=> !tx_irq_out)
    else $error("transmit interrupt before shifter empty");
  a_scratch_rst: assert property ($past(reset_in) |-> st.scratch_pad == SPR_RST)
    else $error("scratch pad reset value");
endmodule

// ### verif/uef_peer.sv
`timescale 1ns/10ps
module uef_peer (
  input  wire logic sys_clk_in,
  input  wire logic bit_tick_in,
  input  wire logic tx_in,
  input  wire logic nine_in,
  input  wire logic inv_in,
  output logic      rx_out
);
  logic       line = 1'b1;
  logic [8:0] got  = '0;
  int         cnt  = 0;
  // Inverted mode idles low so the receiver never sees a false start
  assign rx_out = line ^ inv_in;
  always begin
    @(negedge tx_in);
    got = '0;
    @(posedge sys_clk_in iff bit_tick_in);
    for (int i = 0; i < (nine_in ? 9 : 8); i++) begin
      @(posedge sys_clk_in iff bit_tick_in);
      got[i] = tx_in;
    end
    cnt++;
  end
  // Bits move half a cycle after a tick, far from the next sample
  task automatic send(input logic [7:0] v);
    logic [9:0] f;
    f = {1'b1, v, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge sys_clk_in iff bit_tick_in);
      @(negedge sys_clk_in);
      line = f[i];
    end
  endtask
endmodule

// ### verif/uef_top_test.sv
`timescale 1ns/10ps
module uef_top_test;
  import uef_pkg::*;
  logic       clk = 0, rst = 1, wr = 0, rd = 0, nin = 0, tick = 0, cts = 1, inv = 0, n9 = 0;
  logic       ce  = 1, dsr = 1;
  logic [3:0] a   = '0;
  logic [7:0] wd  = '0, rdata, d;
  logic [4:0] lvl = '0;
  logic [2:0] tc  = '0;
  logic [8:0] rxd;
  logic [1:0] tfs, rfs;
  logic       txr, tx, rx, rts, dtr, rxv, mirq, tirq, sirq, xirq, qirq;
  int         num_errors = 0, tests_run = 0, nv = 0, c0 = 0, k;

  uef_top #(.LW(5), .DEPTH(4)) uef_top_i (
    .sys_clk_in(clk), .reset_in(rst), .ce_in(ce), .reg_addr_in(a),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wd), .reg_rdata_out(rdata),
    .tx_ninth_in(nin), .tx_ready_out(txr), .bit_tick_in(tick), .rx_in(rx),
    .cts_n_in(cts), .dsr_n_in(dsr), .rx_level_in(lvl), .rx_trig_in(5'h08),
    .rx_upper_in(5'h0C), .rx_lower_in(5'h04), .tx_out(tx), .rts_n_out(rts),
    .dtr_n_out(dtr), .rx_data_out(rxd), .rx_valid_out(rxv), .modem_irq_out(mirq),
    .tx_irq_out(tirq), .special_irq_out(sirq), .xoff_irq_out(xirq),
    .rx_trig_irq_out(qirq), .tx_flow_sel_out(tfs), .rx_flow_sel_out(rfs));
  uef_peer peer_i (.sys_clk_in(clk), .bit_tick_in(tick), .tx_in(tx), .nine_in(n9),
    .inv_in(inv), .rx_out(rx));

  always #10 clk = ~clk;
  // Short bit time keeps frames near 80 cycles
  always @(negedge clk) begin
    tc <= tc + 3'h1;
    tick <= (tc == 3'h7);
  end
  always @(posedge clk) if (rxv === 1'b1) nv++;

  task automatic chk(input logic [8:0] g, input logic [8:0] e);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic put_reg(input logic [3:0] ad, input logic [7:0] v);
    @(negedge clk);
    a = ad;
    wd = v;
    wr = 1;
    @(negedge clk);
    wr = 0;
  endtask
  task automatic get_reg(input logic [3:0] ad);
    @(negedge clk);
    a = ad;
    rd = 1;
    @(negedge clk);
    rd = 0;
    d = rdata;
  endtask
  task automatic put(input logic [8:0] v);
    c0 = peer_i.cnt;
    nin = v[8];
    put_reg(A_THR, v[7:0]);
  endtask
  task automatic got(input logic [8:0] v);
    for (k = 0; k < 300 && peer_i.cnt == c0; k++) @(negedge clk);
    chk(peer_i.got, v);
    // Next wait then expects the following frame
    c0 = peer_i.cnt;
  endtask
  task automatic stall;
    repeat (200) @(negedge clk);
    chk(9'(peer_i.cnt - c0), 9'h0);
  endtask
  task automatic rxc(input logic [7:0] v, input logic [8:0] n);
    int n0;
    n0 = nv;
    peer_i.send(v);
    repeat (16) @(negedge clk);
    chk(9'(nv - n0), n);
    if (n != 0) chk(rxd, {1'b0, v});
  endtask
  task automatic set_inv(input logic i, input logic [7:0] f);
    @(posedge clk iff tick);
    @(negedge clk);
    inv = i;
    put_reg(A_FEATURE_CONTROL, f);
  endtask

  task automatic t_reset;
    chk({tx, rts, dtr, tirq, txr}, 9'h1F);
    get_reg(A_SPR);
    chk(d, SPR_RST);
    put_reg(A_SPR, 8'h5A);
    get_reg(A_SPR);
    chk(d, 8'h5A);
    // Write while the clock enable is low must be lost
    ce = 0;
    put_reg(A_SPR, 8'h00);
    ce = 1;
    get_reg(A_SPR);
    chk(d, 8'h5A);
    get_reg(A_EFR);
    chk({d, rfs[0]}, 9'h0);
    get_reg(4'hF);
    chk(d, 8'h00);
  endtask
  task automatic t_gate;
    put_reg(A_MCR, 8'hFF);
    get_reg(A_MCR);
    chk(d, 8'h13);
    put_reg(A_LAC, 8'hFC);
    put_reg(A_EFR, 8'h10);
    put_reg(A_MCR, 8'hFF);
    get_reg(A_MCR);
    chk(d, 8'hFF);
    put_reg(A_MCR, 8'h00);
    put_reg(A_EFR, 8'h1B);
    chk({tfs, rfs}, 9'hB);
    get_reg(A_EFR);
    chk(d, 8'h1B);
    put_reg(A_EFR, 8'h10);
  endtask
  task automatic t_tx;
    put(9'h0A5);
    got(9'h0A5);
    chk(tirq, 1'b1);
    put_reg(A_LAC, 8'h01);
    n9 = 1;
    put(9'h196);
    got(9'h196);
    // Let the stop bit finish so the halt starts from idle
    repeat (20) @(negedge clk);
    put_reg(A_LAC, 8'h08);
    n9 = 0;
    put(9'h033);
    put(9'h044);
    put(9'h066);
    put(9'h077);
    chk(txr, 1'b0);
    put(9'h088);
    stall;
    put_reg(A_LAC, 8'h00);
    got(9'h033);
    got(9'h044);
    got(9'h066);
    got(9'h077);
    stall;
  endtask
  task automatic t_485;
    put_reg(A_FEATURE_CONTROL, 8'h20);
    put_reg(A_LAC, 8'h30);
    chk(rts, 1'b0);
    put(9'h055);
    for (k = 0; k < 20 && rts !== 1'b1; k++) @(negedge clk);
    chk(tx, 1'b1);
    got(9'h055);
    chk(tirq, 1'b0);
    // Stop bit's own tick plus the programmed delay of three
    k = 0;
    while (rts === 1'b1 && k < 40) begin
      @(negedge clk);
      if (tick === 1'b1) k++;
    end
    chk(9'(k), 9'h4);
    put_reg(A_FEATURE_CONTROL, 8'h00);
    put_reg(A_LAC, 8'h00);
  endtask
  task automatic t_rx;
    rxc(8'h3C, 9'h1);
    set_inv(1'b1, 8'h10);
    rxc(8'hA3, 9'h1);
    set_inv(1'b0, 8'h00);
    put_reg(A_LAC, 8'h04);
    rxc(8'h11, 9'h1);
    rxc(8'h22, 9'h0);
    put_reg(A_LAC, 8'h00);
    rxc(8'h33, 9'h1);
  endtask
  task automatic t_spec;
    put_reg(A_SECOND_STOP_CHARACTER, 8'h7E);
    put_reg(A_EFR, 8'h30);
    rxc(8'h7E, 9'h1);
    get_reg(A_ISR);
    chk({d[4], sirq}, 9'h2);
    put_reg(A_EFR, 8'h10);
    put_reg(A_EFR, 8'h31);
    rxc(8'h7E, 9'h0);
    chk({xirq, sirq}, 9'h3);
    get_reg(A_ISR);
    put_reg(A_EFR, 8'h10);
  endtask
  task automatic t_flow;
    put_reg(A_IER, 8'h08);
    get_reg(A_MS);
    cts = 0;
    repeat (8) @(negedge clk);
    chk(mirq, 1'b1);
    get_reg(A_MS);
    chk({d, mirq}, 9'h22);
    put_reg(A_EFR, 8'h90);
    cts = 1;
    // Pin needs four cycles through the synchroniser before a load
    repeat (6) @(negedge clk);
    put(9'h05A);
    stall;
    cts = 0;
    got(9'h05A);
    put_reg(A_EFR, 8'h50);
    put_reg(A_MCR, 8'h02);
    chk(rts, 1'b0);
    lvl = 5'h0C;
    repeat (4) @(negedge clk);
    chk({rts, qirq}, 9'h3);
    lvl = 5'h02;
    repeat (4) @(negedge clk);
    chk({rts, qirq}, 9'h0);
  endtask
  task automatic t_dsr;
    put_reg(A_MCR, 8'h05);
    chk({dtr, rts}, 9'h1);
    lvl = 5'h0C;
    repeat (4) @(negedge clk);
    chk({dtr, rts}, 9'h3);
    lvl = 5'h02;
    repeat (4) @(negedge clk);
    chk({dtr, rts}, 9'h1);
    put_reg(A_EFR, 8'h90);
    dsr = 1;
    repeat (6) @(negedge clk);
    put(9'h0C3);
    stall;
    // Clear-to-send high must not matter once the other pair is chosen
    dsr = 0;
    cts = 1;
    got(9'h0C3);
  endtask

  task automatic end_sim;
    $display("errors %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    #400000;
    num_errors++;
    end_sim;
  end
  initial begin
    repeat (5) @(negedge clk);
    rst = 0;
    t_reset;
    t_gate;
    t_tx;
    t_485;
    t_rx;
    t_spec;
    t_flow;
    t_dsr;
    end_sim;
  end
endmodule
